// >>> core/scfd_pwm.sv
/*
 * duty generator: a periodic ramp from 0.5 V to 3 V compared with the speed command,
 * the command first limited by the lowest speed level.
 * assumes its inputs are registered in the same clock domain.
 */
`timescale 1ns/1ps
module scfd_pwm (
	input  wire logic  clk,
	input  wire logic  rst,
	scfd_pwm_if.gen    pwm
);
	logic [scfd_pkg::RAMP_W-1:0] ramp_pos;
	logic [23:0]                 ramp_prod;
	logic [scfd_pkg::MV_W-1:0]   ramp_mv;
	logic [scfd_pkg::MV_W-1:0]   eff_mv;

	// ------------------------------------------------------------
	// ramp position
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst || ramp_pos == scfd_pkg::RAMP_W'(scfd_pkg::RAMP_CYCLES - 1)) begin
			ramp_pos <= '0;
		end else begin
			ramp_pos <= ramp_pos + 1'b1;
		end
	end

	// RULE_03: ramp level mapping
	assign ramp_prod = (24'(ramp_pos) * scfd_pkg::RAMP_SPAN_MV) / 24'(scfd_pkg::RAMP_CYCLES);
	assign ramp_mv   = scfd_pkg::RAMP_LO_MV + ramp_prod[scfd_pkg::MV_W-1:0];

	// RULE_05: floor by level
	assign eff_mv = (pwm.cmd_mv < pwm.floor_mv) ? pwm.cmd_mv : pwm.floor_mv;

	// RULE_04: compare gives duty
	always_ff @(posedge clk) begin
		if (rst) begin
			pwm.pwm_on <= 1'b0;
		end else begin
			pwm.pwm_on <= pwm.force_full || (eff_mv < ramp_mv);  // below ramp drives
		end
	end
endmodule

// >>> core/scfd_top.sv
/*
 * single coil fan drive control: pole comparator, coil commutation, tach output,
 * duty gating, current limit, locked-rotor shutdown with restart, quick stop and start.
 * assumes field, command, level and sense codes come from converters on CLK_SYS.
 */
// Notes on behaviour
// RULE_01: no pole edge for 0.3 s while driving stops the coil outputs.
// RULE_02: after a locked shutdown, drive resumes by itself after 4.2 s.
// RULE_03: duty comes from command compared to a 0.5 V to 3 V ramp.
// RULE_04: duty is -40 times (command minus 3) percent, clamped 100 to 0.
// RULE_05: running duty never drops below the duty set by the lowest speed level.
// RULE_06: every start runs at full duty first, ignoring command and floor.
// RULE_07: an open or grounded command input gives full speed.
// RULE_08: command above 3 V for over 25 ms stops motor, lock protection off.
// RULE_09: from stop, command back within zero to level restarts at once.
// RULE_10: sense voltage above 250 mV cuts coil drive to limit current.
// RULE_11: field above +15 G operates, below -15 G releases, else holds.
// RULE_12: release gives A high, B low, tach high; operate the reverse.
// RULE_13: every pole edge restarts the lock timer.
`timescale 1ns/1ps
module scfd_top #(
	parameter logic [27:0] LOCK_CYCLES    = 28'(scfd_pkg::LOCK_CYCLES),
	parameter logic [27:0] RESTART_CYCLES = 28'(scfd_pkg::RESTART_CYCLES),
	parameter logic [27:0] STOP_CYCLES    = 28'(scfd_pkg::STOP_CYCLES)
) (
	input  wire logic                               CLK_SYS,
	input  wire logic                               RST,
	input  wire logic signed [scfd_pkg::FIELD_W-1:0] FIELD_GAUSS,
	input  wire logic [scfd_pkg::MV_W-1:0]          SPEED_CMD_MV,
	input  wire logic [scfd_pkg::MV_W-1:0]          LOWEST_SPEED_LEVEL_MV,
	input  wire logic [scfd_pkg::SENSE_W-1:0]       SENSE_RESISTOR_MV,
	output      logic                               COIL_DRIVE_A,
	output      logic                               COIL_DRIVE_B,
	output      logic                               TACH_OUTPUT,
	output      logic                               LOCK_SHUTDOWN,
	output      logic                               SPEED_STOPPED,
	output      logic                               CURRENT_LIMITED
);
	scfd_pwm_if              pwm ();
	scfd_pkg::scfd_state_t   state;
	logic                    pole;        // 1 operate, 0 release
	logic                    pole_prev;
	logic                    pole_edge;
	logic [27:0]             lock_cnt;
	logic [27:0]             stop_cnt;
	logic [1:0]              start_cnt;
	logic                    stop_hit;
	logic                    drive_en;

	// ------------------------------------------------------------
	// level compares shared by several processes
	// ------------------------------------------------------------
	// sense level beyond the current limit
	function automatic logic over_limit(input logic [scfd_pkg::SENSE_W-1:0] mv);
		return (mv > scfd_pkg::CUR_LIMIT_MV);
	endfunction

	// a millivolt code at or below a reference level
	function automatic logic at_or_below(input logic [scfd_pkg::MV_W-1:0] mv,
	                                     input logic [scfd_pkg::MV_W-1:0] lvl);
		return (mv <= lvl);
	endfunction

	// ------------------------------------------------------------
	// duty generator
	// ------------------------------------------------------------
	scfd_pwm u_pwm (
		.clk (CLK_SYS),
		.rst (RST),
		.pwm (pwm)
	);

	// RULE_07: grounded command reads as full
	assign pwm.cmd_mv     = SPEED_CMD_MV;
	assign pwm.floor_mv   = LOWEST_SPEED_LEVEL_MV;
	// RULE_06: full duty at start
	assign pwm.force_full = (start_cnt != scfd_pkg::START_EDGES);

	// ------------------------------------------------------------
	// pole comparator
	// ------------------------------------------------------------
	// RULE_11: hysteresis pole compare
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			pole <= 1'b0;
		end else if (FIELD_GAUSS > scfd_pkg::OPERATE_G) begin
			pole <= 1'b1;
		end else if (FIELD_GAUSS < scfd_pkg::RELEASE_G) begin
			pole <= 1'b0;
		end
	end

	// edge detect on the held pole state
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			pole_prev <= 1'b0;
		end else begin
			pole_prev <= pole;
		end
	end
	assign pole_edge = pole ^ pole_prev;

	// ------------------------------------------------------------
	// quick stop detector
	// ------------------------------------------------------------
	// RULE_08: high command timer
	always_ff @(posedge CLK_SYS) begin
		if (RST || at_or_below(SPEED_CMD_MV, scfd_pkg::RAMP_HI_MV)) begin
			stop_cnt <= '0;
		end else if (stop_cnt != STOP_CYCLES) begin
			stop_cnt <= stop_cnt + 1'b1;
		end
	end
	assign stop_hit = (stop_cnt == STOP_CYCLES);

	// ------------------------------------------------------------
	// run state and timers
	// ------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			state <= scfd_pkg::ST_RUN;
		end else begin
			case (state)
				scfd_pkg::ST_RUN: begin
					if (stop_hit) begin
						state <= scfd_pkg::ST_STOPPED;
					// RULE_01: lock shutdown
					end else if (lock_cnt == LOCK_CYCLES) begin
						state <= scfd_pkg::ST_LOCKED;
					end
				end
				scfd_pkg::ST_LOCKED: begin
					if (stop_hit) begin
						state <= scfd_pkg::ST_STOPPED;
					// RULE_02: timed restart
					end else if (lock_cnt == RESTART_CYCLES) begin
						state <= scfd_pkg::ST_RUN;
					end
				end
				scfd_pkg::ST_STOPPED: begin
					// RULE_09: immediate start
					if (at_or_below(SPEED_CMD_MV, LOWEST_SPEED_LEVEL_MV)) begin
						state <= scfd_pkg::ST_RUN;
					end
				end
				default: begin
					state <= scfd_pkg::ST_RUN;
				end
			endcase
		end
	end

	// lock and restart timer, shared by both waits
	// one counter is enough since the two waits never overlap
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			lock_cnt <= '0;
		end else begin
			case (state)
				scfd_pkg::ST_RUN: begin
					// RULE_13: edge restarts timer
					if (pole_edge || stop_hit || lock_cnt == LOCK_CYCLES) begin
						lock_cnt <= '0;
					end else begin
						lock_cnt <= lock_cnt + 1'b1;
					end
				end
				scfd_pkg::ST_LOCKED: begin
					if (lock_cnt == RESTART_CYCLES || stop_hit) begin
						lock_cnt <= '0;
					end else begin
						lock_cnt <= lock_cnt + 1'b1;
					end
				end
				default: begin
					lock_cnt <= '0;  // protection off while stopped
				end
			endcase
		end
	end

	// start window counts pole edges after each entry to run
	// a stalled rotor never closes the window, the lock timer still guards it
	always_ff @(posedge CLK_SYS) begin
		if (RST || state != scfd_pkg::ST_RUN) begin
			start_cnt <= '0;
		end else if (pole_edge && start_cnt != scfd_pkg::START_EDGES) begin
			start_cnt <= start_cnt + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// RULE_10: current limit gate
	assign drive_en = (state == scfd_pkg::ST_RUN) && pwm.pwm_on &&
	                  !over_limit(SENSE_RESISTOR_MV);

	// RULE_12: commutation and tach
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			COIL_DRIVE_A <= 1'b0;
			COIL_DRIVE_B <= 1'b0;
			TACH_OUTPUT  <= 1'b1;
		end else begin
			COIL_DRIVE_A <= drive_en && !pole;
			COIL_DRIVE_B <= drive_en && pole;
			TACH_OUTPUT  <= !pole;
		end
	end

	// status flags
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			LOCK_SHUTDOWN   <= 1'b0;
			SPEED_STOPPED   <= 1'b0;
			CURRENT_LIMITED <= 1'b0;
		end else begin
			LOCK_SHUTDOWN   <= (state == scfd_pkg::ST_LOCKED);
			SPEED_STOPPED   <= (state == scfd_pkg::ST_STOPPED);
			CURRENT_LIMITED <= over_limit(SENSE_RESISTOR_MV);
		end
	end
endmodule

// >>> shared/scfd_pkg.sv
/*
 * constants for the single coil fan drive control block: clock rate, protection times,
 * ramp span, comparator thresholds and the one-hot state codes.
 * assumes the block runs on one 40 MHz clock and every analog level except the gauss field arrives as a millivolt code.
 */
package scfd_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 32'h0262_5A00;   // 40 MHz
	localparam int unsigned LOCK_TIME_MS    = 32'h0000_012C;   // 300 ms locked before shutdown
	localparam int unsigned RESTART_TIME_MS = 32'h0000_1068;   // 4200 ms off before restart
	localparam int unsigned STOP_TIME_US    = 32'h0000_61A8;   // 25000 us high command to stop
	localparam int unsigned PWM_HZ          = 32'h0000_61A8;   // 25 kHz ramp rate
	localparam int unsigned LOCK_CYCLES     = LOCK_TIME_MS * (CLK_HZ / 32'h0000_03E8);
	localparam int unsigned RESTART_CYCLES  = RESTART_TIME_MS * (CLK_HZ / 32'h0000_03E8);
	localparam int unsigned STOP_CYCLES     = STOP_TIME_US * (CLK_HZ / 32'h000F_4240);
	localparam int unsigned RAMP_CYCLES     = CLK_HZ / PWM_HZ;  // 1600 cycles a ramp period

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int unsigned MV_W    = 12;   // millivolt codes 0..4095
	localparam int unsigned CNT_W   = 28;   // long timers
	localparam int unsigned RAMP_W  = 11;   // ramp position counter
	localparam int unsigned FIELD_W = 8;    // signed gauss
	localparam int unsigned SENSE_W = 10;   // current sense millivolts

	// ----------------------------------------------------------------
	// levels
	// ----------------------------------------------------------------
	localparam logic [MV_W-1:0]    RAMP_LO_MV   = 12'h1F4;  // 500 mV
	localparam logic [MV_W-1:0]    RAMP_HI_MV   = 12'hBB8;  // 3000 mV, also the stop level
	localparam logic [23:0]        RAMP_SPAN_MV = 24'h00_09C4;  // 2500 mV
	localparam logic [SENSE_W-1:0] CUR_LIMIT_MV = 10'h0FA;  // 250 mV
	localparam logic signed [FIELD_W-1:0] OPERATE_G = 8'sh0F;   // +15 gauss
	localparam logic signed [FIELD_W-1:0] RELEASE_G = -8'sh0F;  // -15 gauss
	localparam logic [1:0]         START_EDGES  = 2'h2;     // pole edges run at full duty

	// ----------------------------------------------------------------
	// run states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_RUN     = 3'b001,
		ST_LOCKED  = 3'b010,
		ST_STOPPED = 3'b100
	} scfd_state_t;

endpackage

// >>> shared/scfd_pwm_if.sv
/*
 * carrier between the fan control core and its duty generator.
 * assumes both ends share the core clock.
 */
`timescale 1ns/1ps
interface scfd_pwm_if;
	logic [scfd_pkg::MV_W-1:0] cmd_mv;      // speed command level
	logic [scfd_pkg::MV_W-1:0] floor_mv;    // lowest speed level
	logic                      force_full;  // start-up full duty
	logic                      pwm_on;      // duty gate

	modport core (output cmd_mv, output floor_mv, output force_full, input pwm_on);
	modport gen  (input cmd_mv, input floor_mv, input force_full, output pwm_on);
endinterface

// >>> testbench/scfd_fan.sv
/* fan rotor and coil model: field from rotation, sense from coil current.
   assumes drive changes shortly after the clock edge. */
`timescale 1ns/1ps
module scfd_fan (
	input  wire logic         clk,
	input  wire logic         stall,
	input  wire logic [9:0]   load_mv,
	input  wire logic         coil_a,
	input  wire logic         coil_b,
	output logic signed [7:0] field = 8'sh00,
	output logic [9:0]        sense = 10'h000
);
	int ph = 0;
	// rotor turns unless stalled; weak field for a while after each pole change
	always @(posedge clk) begin
		ph = stall ? 0 : (ph + 1) % 80;
		field <= #2 (stall || ph % 40 < 8) ? 8'(int'($urandom_range(30)) - 15) : (ph < 40 ? 8'sh10 : -8'sh10);
		sense <= #2 (coil_a || coil_b) ? load_mv : 10'h000;
	end
endmodule

// >>> testbench/scfd_props.sv
/* checker on the scfd_top ports.
   assumes one clock and a synchronous active high reset. */
`timescale 1ns/1ps
module scfd_props #(
	parameter logic [27:0] LOCK_CYCLES    = 28'h000_00C8,
	parameter logic [27:0] RESTART_CYCLES = 28'h000_01F4,
	parameter logic [27:0] STOP_CYCLES    = 28'h000_0032
) (
	input wire logic              CLK_SYS,
	input wire logic              RST,
	input wire logic signed [7:0] FIELD_GAUSS,
	input wire logic [11:0]       SPEED_CMD_MV,
	input wire logic [11:0]       LOWEST_SPEED_LEVEL_MV,
	input wire logic [9:0]        SENSE_RESISTOR_MV,
	input wire logic              COIL_DRIVE_A,
	input wire logic              COIL_DRIVE_B,
	input wire logic              TACH_OUTPUT,
	input wire logic              LOCK_SHUTDOWN,
	input wire logic              SPEED_STOPPED,
	input wire logic              CURRENT_LIMITED
);
	logic tach_d;
	int   still;
	int   lock_len;
	int   hi_len;
	// quiet rotor, shutdown length and high command run lengths
	always_ff @(posedge CLK_SYS) begin
		tach_d   <= TACH_OUTPUT;
		still    <= (RST || TACH_OUTPUT != tach_d || LOCK_SHUTDOWN || SPEED_STOPPED) ? 0 : still + 1;
		lock_len <= (RST || !LOCK_SHUTDOWN) ? 0 : lock_len + 1;
		hi_len   <= (RST || SPEED_CMD_MV <= 12'hBB8) ? 0 : hi_len + 1;
	end
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	sequence s_cmd_high;
		hi_len == STOP_CYCLES + 1;
	endsequence
	a_pole_operate: assert property (FIELD_GAUSS > 8'sh0F |-> ##2 !TACH_OUTPUT)
		else $error("tach high after operate field");
	a_pole_release: assert property (FIELD_GAUSS < -8'sh0F |-> ##2 TACH_OUTPUT)
		else $error("tach low after release field");
	a_pole_hold: assert property (FIELD_GAUSS <= 8'sh0F && FIELD_GAUSS >= -8'sh0F |=> ##1 $stable(TACH_OUTPUT))
		else $error("tach moved inside band");
	a_release_b_off: assert property (TACH_OUTPUT |-> !COIL_DRIVE_B)
		else $error("coil b on in release");
	a_operate_a_off: assert property (!TACH_OUTPUT |-> !COIL_DRIVE_A)
		else $error("coil a on in operate");
	a_current_cut: assert property (SENSE_RESISTOR_MV > 10'h0FA |=> !COIL_DRIVE_A && !COIL_DRIVE_B && CURRENT_LIMITED)
		else $error("drive not cut over limit");
	a_halt_quiet: assert property (LOCK_SHUTDOWN || SPEED_STOPPED |-> !COIL_DRIVE_A && !COIL_DRIVE_B)
		else $error("coil driven while halted");
	a_lock_bound: assert property (still <= LOCK_CYCLES + 5)
		else $error("no shutdown after quiet rotor");
	a_restart_time: assert property ($fell(LOCK_SHUTDOWN) && !SPEED_STOPPED && !$past(RST) |-> lock_len == RESTART_CYCLES + 1)
		else $error("shutdown length wrong");
	a_stop_reach: assert property (s_cmd_high |-> ##[0:3] SPEED_STOPPED)
		else $error("no stop after high command");
	a_quick_start: assert property (SPEED_STOPPED && SPEED_CMD_MV <= LOWEST_SPEED_LEVEL_MV |-> ##[1:2] !SPEED_STOPPED)
		else $error("no quick start");
endmodule
bind scfd_top scfd_props #(.LOCK_CYCLES(LOCK_CYCLES), .RESTART_CYCLES(RESTART_CYCLES), .STOP_CYCLES(STOP_CYCLES))
	props_u (.CLK_SYS(CLK_SYS), .RST(RST), .FIELD_GAUSS(FIELD_GAUSS), .SPEED_CMD_MV(SPEED_CMD_MV),
	.LOWEST_SPEED_LEVEL_MV(LOWEST_SPEED_LEVEL_MV), .SENSE_RESISTOR_MV(SENSE_RESISTOR_MV),
	.COIL_DRIVE_A(COIL_DRIVE_A), .COIL_DRIVE_B(COIL_DRIVE_B), .TACH_OUTPUT(TACH_OUTPUT),
	.LOCK_SHUTDOWN(LOCK_SHUTDOWN), .SPEED_STOPPED(SPEED_STOPPED), .CURRENT_LIMITED(CURRENT_LIMITED));

// >>> testbench/tb.sv
/* self-checking bench for scfd_top with the fan model on the coil side.
   assumes the checker is bound in by its own file. */
`timescale 1ns/1ps
module tb;
	localparam logic [27:0] LOCK    = 28'h000_00C8;
	localparam logic [27:0] RESTART = 28'h000_01F4;
	localparam logic [27:0] STOP    = 28'h000_0032;
	logic              CLK_SYS = 0, RST = 1, stall = 1;
	logic [11:0]       cmd = 12'hBB8, level = 12'hFFF;
	logic [9:0]        load = 10'h000, sense;
	logic signed [7:0] field;
	logic              a, b, tach, lock, stopped, limited;
	logic              model_pole = 0, model_tach = 1;
	int                n_mismatch = 0, tests_run = 0, n;
	always #12.5 CLK_SYS = ~CLK_SYS;
	scfd_fan fan_u (.clk(CLK_SYS), .stall(stall), .load_mv(load), .coil_a(a), .coil_b(b), .field(field), .sense(sense));
	scfd_top #(.LOCK_CYCLES(LOCK), .RESTART_CYCLES(RESTART), .STOP_CYCLES(STOP)) dut_u (.CLK_SYS(CLK_SYS), .RST(RST),
		.FIELD_GAUSS(field), .SPEED_CMD_MV(cmd), .LOWEST_SPEED_LEVEL_MV(level), .SENSE_RESISTOR_MV(sense),
		.COIL_DRIVE_A(a), .COIL_DRIVE_B(b), .TACH_OUTPUT(tach), .LOCK_SHUTDOWN(lock), .SPEED_STOPPED(stopped),
		.CURRENT_LIMITED(limited));
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic tick(int k);
		repeat (k) @(posedge CLK_SYS);
		#2;
	endtask
	// ON cycles over one ramp period against the ramp reference
	task automatic duty(logic [11:0] c, logic [11:0] l);
		logic [31:0] on;
		int          exp;
		on = 0;
		exp = 0;
		cmd = c;
		level = l;
		tick(100);
		for (int p = 0; p < 1600; p++) begin
			exp += (500 + p * 2500 / 1600 > (c < l ? c : l));
			on += a | b;
			tick(1);
		end
		check("duty", on, exp);
	endtask
	// pole model and coil pairing each cycle
	always @(posedge CLK_SYS) begin
		model_pole <= RST ? 1'b0 : field > 15 ? 1'b1 : field < -15 ? 1'b0 : model_pole;
		model_tach <= RST | !model_pole;
		#1;
		if (!RST) check("tach", tach, model_tach);
		if (!RST) check("coil pair", {a & !tach, b & tach, a & b}, 3'h0);
	end
	initial begin
		void'($urandom(32'h0000_D7E6));
		tick(2);
		RST = 0;
		// full duty at start despite a stop-level command
		tick(5);
		check("start drive", {a, b}, 2'b10);
		n = 5;
		while (lock !== 1 && n < 400) begin
			tick(1);
			n++;
		end
		check("lock time", n >= LOCK && n <= LOCK + 4, 1);
		n = 0;
		while (lock === 1 && n < 1000) begin
			tick(1);
			n++;
		end
		check("restart time", n, RESTART + 1);
		tick(3);
		check("restart drive", a | b, 1);
		stall = 0;
		duty(12'h000, 12'hFFF);
		duty(12'h1F4, 12'hFFF);
		duty(12'h3E8, 12'hFFF);
		duty(12'hBB8, 12'hFFF);
		duty(12'h9C4, 12'h3E8);
		duty(12'(500 + $urandom_range(2499)), 12'hFFF);
		check("no lock while turning", lock, 0);
		// limit level exact, then above it
		load = 10'h0FA;
		duty(12'h000, 12'hFFF);
		check("no limit at level", limited, 0);
		load = 10'h0FB;
		repeat (40) begin
			// the fan settles sense after this point in the step, so read it a little later
			#1;
			n = sense > 10'h0FA;
			tick(1);
			if (n) check("limit cut", {a, b, limited}, 3'b001);
		end
		load = 10'h000;
		level = 12'h3E8;
		cmd = 12'hDAC;
		tick(STOP - 5);
		cmd = 12'h000;
		tick(3);
		check("short high", stopped, 0);
		cmd = 12'hDAC;
		tick(STOP + 4);
		stall = 1;
		check("stopped", {stopped, a, b}, 3'b100);
		tick(LOCK + 20);
		check("no lock when stopped", lock, 0);
		cmd = 12'h7D0;
		tick(5);
		check("stays stopped", stopped, 1);
		cmd = 12'h3E8;
		stall = 0;
		tick(2);
		check("quick start", stopped, 0);
		tick(1);
		check("quick drive", a | b, 1);
		complete_run();
	end
	// watchdog
	initial begin
		repeat (40000) @(posedge CLK_SYS);
		n_mismatch++;
		complete_run();
	end
endmodule
